// ==== hdl/tvd_core.sv ====
// Digital side of a three-channel 8-bit flash converter: comparator
// capture, encoder, dither with correction, output pipeline, clamp control.
// Assumes analog levels arrive already quantised to half-LSB steps and
// the level-select pad is decoded to two bits by the pad cell.
`timescale 1ns/1ns
`default_nettype none

module tvd_core #(
  parameter int BUF_DEPTH = tvd_pkg::FIFO_DEPTH
) (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire logic [tvd_pkg::LEVEL_W-1:0] red_level_in,
  input  wire logic [tvd_pkg::LEVEL_W-1:0] green_level_in,
  input  wire logic [tvd_pkg::LEVEL_W-1:0] blue_level_in,
  input  wire logic                        line_sync_in,
  input  wire logic                        frame_sync_in,
  input  wire logic [1:0]                  level_sel_in,
  output logic      [tvd_pkg::CODE_W-1:0]  red_code_out,
  output logic      [tvd_pkg::CODE_W-1:0]  green_code_out,
  output logic      [tvd_pkg::CODE_W-1:0]  blue_code_out,
  output tvd_pkg::tvd_rgb_t                clamp_level_out,
  output logic                             clamp_integrate_out,
  output logic      [tvd_pkg::NUM_CH-1:0]  clamp_sink_out,
  output logic      [tvd_pkg::NUM_CH-1:0]  clamp_source_out,
  output logic                             buf_in_ready,
  output logic                             stream_valid,
  input  wire logic                        stream_ready,
  output tvd_pkg::tvd_rgb_t                stream_data
);

  // ========================================================================
  // Declarations
  // ========================================================================
  localparam int NCH = tvd_pkg::NUM_CH;
  localparam int CW  = tvd_pkg::CODE_W;
  localparam int DW  = tvd_pkg::DITH_W;
  localparam int SS  = tvd_pkg::SYNC_STAGES;
  localparam int AW  = tvd_pkg::ACC_W;

  // Pin synchronisers and filtered sync levels
  logic [SS-1:0] lsync_q, lsync_d;   // Line sync shift chain
  logic [SS-1:0] fsync_q, fsync_d;   // Frame sync shift chain
  logic          lfilt_q, lfilt_d;   // Accepted line sync level
  logic          ffilt_q, ffilt_d;   // Accepted frame sync level
  logic          line_rise;          // Line pulse start
  logic          line_fall;          // Line pulse end
  logic          frame_fall;         // Frame pulse (active low)

  // Dither state
  logic [DW-1:0] dith_q, dith_d;     // Counter, offset in half LSBs
  logic          fpar_q, fpar_d;     // Odd/even frame pulse
  logic [DW-1:0] dith_off;           // Offset applied this sample

  // Capture stage (falling edge) and rising-edge pipeline
  logic [NCH-1:0][tvd_pkg::LEVEL_W-1:0] level;
  logic [NCH-1:0][tvd_pkg::NUM_CMP-1:0] therm_q, therm_d;
  logic [DW-2:0] whole_s_q, whole_s_d;   // Whole-LSB part at capture
  logic [DW-2:0] whole_a_q, whole_a_d;   // Travels with encoder stage
  logic [NCH-1:0][CW-1:0] raw_q, raw_d;  // Encoder output
  logic [NCH-1:0][CW-1:0] corr_q, corr_d;  // Corrected code
  logic [NCH-1:0][CW-1:0] out_q, out_d;  // Pin registers
  logic [tvd_pkg::PIPE_POS-1:0] vld_q, vld_d;  // Pipeline fill marks

  // Clamp control
  tvd_pkg::tvd_clamp_t cl_q, cl_d;       // Clamp phase
  logic [NCH-1:0][CW-1:0] target;        // Clamp target codes
  logic [NCH-1:0][AW-1:0] acc_q, acc_d;  // Error integrators
  logic [NCH-1:0]         pos_q, pos_d;  // Latched sign: above target
  logic [NCH-1:0]         neg_q, neg_d;  // Latched sign: below target

  tvd_pkg::tvd_rgb_t      out_word;

  // Encoder: count set comparators of a thermometer code
  function automatic logic [CW-1:0] encode(
    input logic [tvd_pkg::NUM_CMP-1:0] t
  );
    logic [CW-1:0] n;
    n = '0;
    for (int i = 0; i < tvd_pkg::NUM_CMP; i++)
    begin
      n = n + CW'(t[i]);
    end
    return n;
  endfunction

  // ========================================================================
  // Sync inputs
  // ========================================================================
  // Three flops per pin; a change is taken once the last two agree
  always_comb
  begin
    lsync_d = {lsync_q[SS-2:0], line_sync_in};
    fsync_d = {fsync_q[SS-2:0], frame_sync_in};
    lfilt_d = (lsync_q[1] == lsync_q[2]) ? lsync_q[2] : lfilt_q;
    ffilt_d = (fsync_q[1] == fsync_q[2]) ? fsync_q[2] : ffilt_q;
  end

  assign line_rise  = lfilt_d && !lfilt_q;
  assign line_fall  = !lfilt_d && lfilt_q;
  assign frame_fall = !ffilt_d && ffilt_q;

  // ========================================================================
  // Dither counter
  // ========================================================================
  // Clearing frame pulse wins over a line step in the same cycle
  always_comb
  begin
    dith_d = dith_q;
    fpar_d = fpar_q;
    if (frame_fall)
    begin
      fpar_d = !fpar_q;
      if (fpar_q)
      begin
        dith_d = tvd_pkg::DITH_RST;
      end
      else if (line_rise)
      begin
        dith_d = dith_q + DW'(1);
      end
    end
    else if (line_rise)
    begin
      dith_d = dith_q + DW'(1);
    end
  end

  // Frame sync low: no offset, no correction
  assign dith_off = ffilt_q ? dith_q : '0;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      lsync_q <= '0;
      fsync_q <= '0;
      lfilt_q <= 1'b0;
      ffilt_q <= 1'b0;
      dith_q  <= tvd_pkg::DITH_RST;
      fpar_q  <= 1'b0;
    end
    else
    begin
      lsync_q <= lsync_d;
      fsync_q <= fsync_d;
      lfilt_q <= lfilt_d;
      ffilt_q <= ffilt_d;
      dith_q  <= dith_d;
      fpar_q  <= fpar_d;
    end
  end

  // ========================================================================
  // Comparator bank, captured on the falling edge
  // ========================================================================
  assign level[tvd_pkg::CH_RED]   = red_level_in;
  assign level[tvd_pkg::CH_GREEN] = green_level_in;
  assign level[tvd_pkg::CH_BLUE]  = blue_level_in;

  // Threshold k sits at k+1 whole LSBs, i.e. 2(k+1) half steps
  for (genvar c = 0; c < NCH; c++)
  begin : g_cmp
    for (genvar k = 0; k < tvd_pkg::NUM_CMP; k++)
    begin : g_thr
      assign therm_d[c][k] =
        ({1'b0, level[c]} + tvd_pkg::SUM_W'(dith_off))
        >= tvd_pkg::SUM_W'(2 * (k + 1));
    end
  end

  // Only the whole-LSB part of the offset is removed later
  assign whole_s_d = dith_off[DW-1:1];

  always_ff @(negedge ref_clk)
  begin
    if (srst)
    begin
      therm_q   <= '0;
      whole_s_q <= '0;
    end
    else
    begin
      therm_q   <= therm_d;
      whole_s_q <= whole_s_d;
    end
  end

  // ========================================================================
  // Output pipeline: rising edges at +0.5, +1.5 and +2.5 periods
  // ========================================================================
  always_comb
  begin
    whole_a_d = whole_s_q;
    vld_d     = {vld_q[tvd_pkg::PIPE_POS-2:0], 1'b1};
    for (int c = 0; c < NCH; c++)
    begin
      raw_d[c] = encode(therm_q[c]);
      // Clip at zero; the top code then tops out one short of full
      if (raw_q[c] < CW'(whole_a_q))
      begin
        corr_d[c] = '0;
      end
      else
      begin
        corr_d[c] = raw_q[c] - CW'(whole_a_q);
      end
      out_d[c] = corr_q[c];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      whole_a_q <= '0;
      raw_q     <= '0;
      corr_q    <= '0;
      out_q     <= '0;
      vld_q     <= '0;
    end
    else
    begin
      whole_a_q <= whole_a_d;
      raw_q     <= raw_d;
      corr_q    <= corr_d;
      out_q     <= out_d;
      vld_q     <= vld_d;
    end
  end

  // Each bus carries its own channel, bit 0 least significant
  assign red_code_out   = out_q[tvd_pkg::CH_RED];
  assign green_code_out = out_q[tvd_pkg::CH_GREEN];
  assign blue_code_out  = out_q[tvd_pkg::CH_BLUE];

  // ========================================================================
  // Output buffer
  // ========================================================================
  // Codes are pushed every cycle; a full buffer drops the word and
  // shows it on buf_in_ready, since a flash converter cannot stall.
  assign out_word = '{red: red_code_out, green: green_code_out,
                      blue: blue_code_out};

  tvd_fifo #(
    .WIDTH ($bits(tvd_pkg::tvd_rgb_t)),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (ref_clk),
    .srst      (srst),
    .in_valid  (vld_q[tvd_pkg::PIPE_POS-1]),
    .in_ready  (buf_in_ready),
    .in_data   (out_word),
    .out_valid (stream_valid),
    .out_ready (stream_ready),
    .out_data  (stream_data)
  );

  // ========================================================================
  // Clamp control
  // ========================================================================
  // Target levels from the three-state select pad
  always_comb
  begin
    target[tvd_pkg::CH_RED]   = tvd_pkg::CLAMP_16;
    target[tvd_pkg::CH_GREEN] = tvd_pkg::CLAMP_16;
    target[tvd_pkg::CH_BLUE]  = tvd_pkg::CLAMP_16;
    if (level_sel_in == tvd_pkg::LSEL_HIGH)
    begin
      target[tvd_pkg::CH_RED]  = tvd_pkg::CLAMP_128;
      target[tvd_pkg::CH_BLUE] = tvd_pkg::CLAMP_128;
    end
    else if (level_sel_in == tvd_pkg::LSEL_OPEN)
    begin
      target[tvd_pkg::CH_RED]   = tvd_pkg::CLAMP_128;
      target[tvd_pkg::CH_GREEN] = tvd_pkg::CLAMP_64;
      target[tvd_pkg::CH_BLUE]  = tvd_pkg::CLAMP_128;
    end
  end

  // Idle until the first line pulse; no pulses, no correction
  always_comb
  begin
    cl_d  = cl_q;
    acc_d = acc_q;
    pos_d = pos_q;
    neg_d = neg_q;
    case (cl_q)
      tvd_pkg::CL_IDLE:
      begin
        if (line_rise)
        begin
          cl_d  = tvd_pkg::CL_INTEG;
          acc_d = '0;
        end
      end
      tvd_pkg::CL_INTEG:
      begin
        // Accumulator wraps on very long pulses; pulses are short
        for (int c = 0; c < NCH; c++)
        begin
          acc_d[c] = acc_q[c] + AW'({1'b0, raw_q[c]})
                     - AW'({1'b0, target[c]});
        end
        if (line_fall)
        begin
          cl_d = tvd_pkg::CL_CORRECT;
          for (int c = 0; c < NCH; c++)
          begin
            pos_d[c] = !acc_q[c][AW-1] && (acc_q[c] != '0);
            neg_d[c] = acc_q[c][AW-1];
          end
        end
      end
      tvd_pkg::CL_CORRECT:
      begin
        if (line_rise)
        begin
          cl_d  = tvd_pkg::CL_INTEG;
          acc_d = '0;
        end
      end
      default:
      begin
        cl_d = tvd_pkg::CL_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cl_q  <= tvd_pkg::CL_IDLE;
      acc_q <= '0;
      pos_q <= '0;
      neg_q <= '0;
    end
    else
    begin
      cl_q  <= cl_d;
      acc_q <= acc_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  // Sink lowers a high input, source raises a low one, only while low
  assign clamp_integrate_out = (cl_q == tvd_pkg::CL_INTEG);
  assign clamp_sink_out   = (cl_q == tvd_pkg::CL_CORRECT) ? pos_q : '0;
  assign clamp_source_out = (cl_q == tvd_pkg::CL_CORRECT) ? neg_q : '0;
  assign clamp_level_out  = '{red:   target[tvd_pkg::CH_RED],
                              green: target[tvd_pkg::CH_GREEN],
                              blue:  target[tvd_pkg::CH_BLUE]};

endmodule
`default_nettype wire

// ==== hdl/tvd_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// FIFO
// ==========================================================================
module tvd_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];     // Storage words
  logic [AW-1:0]    wr_q, wr_d;      // Write pointer
  logic [AW-1:0]    rd_q, rd_d;      // Read pointer
  logic [AW:0]      cnt_q, cnt_d;    // Fill level
  logic             push;
  logic             pop;

  // Full and empty straight from the fill level
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and level update, wrap at DEPTH
  always_comb
  begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push)
    begin
      wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
    end
    if (pop)
    begin
      rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
    end
    if (push && !pop)
    begin
      cnt_d = cnt_q + (AW+1)'(1);
    end
    else if (pop && !push)
    begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  // Registers; storage is not reset, only the pointers and fill level
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
    if (srst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/tvd_pkg.sv ====
// Shared constants and carrier types for the triple video converter core.
// Assumes one 125 MHz clock and a synchronous active-high reset.

// ==========================================================================
// Package
// ==========================================================================
package tvd_pkg;

  // Code and level widths
  localparam int CODE_W   = 8;      // Output code width per channel
  localparam int LEVEL_W  = 9;      // Sampled level in half-LSB units
  localparam int SUM_W    = 10;     // Level plus dither offset
  localparam int NUM_CMP  = 255;    // Thresholds between 256 codes
  localparam int NUM_CH   = 3;      // Red, green, blue
  localparam int CH_RED   = 0;      // Channel index of red / V
  localparam int CH_GREEN = 1;      // Channel index of green / luma
  localparam int CH_BLUE  = 2;      // Channel index of blue / U

  // Dither counter
  localparam int DITH_W = 2;        // Counter width, offset in half LSBs
  localparam logic [DITH_W-1:0] DITH_RST = 2'h0;  // Value after reset

  // Input synchroniser depth and pipeline latency
  localparam int SYNC_STAGES = 3;   // Pin synchroniser flip-flops
  localparam int PIPE_POS    = 3;   // Rising edges after sampling edge

  // Clamp integrator
  localparam int ACC_W = 20;        // Integrator accumulator width

  // Level-select pad decode
  localparam logic [1:0] LSEL_LOW  = 2'h0;  // Pad driven low
  localparam logic [1:0] LSEL_HIGH = 2'h1;  // Pad driven high
  localparam logic [1:0] LSEL_OPEN = 2'h2;  // Pad left open

  // Clamp target codes out of 256
  localparam logic [CODE_W-1:0] CLAMP_16  = 8'h10;
  localparam logic [CODE_W-1:0] CLAMP_64  = 8'h40;
  localparam logic [CODE_W-1:0] CLAMP_128 = 8'h80;

  // Output buffer depth
  localparam int FIFO_DEPTH = 8;

  // One code per channel, moved as a unit
  typedef struct packed {
    logic [CODE_W-1:0] red;
    logic [CODE_W-1:0] green;
    logic [CODE_W-1:0] blue;
  } tvd_rgb_t;

  // Clamp phase, one-hot
  typedef enum logic [2:0] {
    CL_IDLE    = 3'h1,
    CL_INTEG   = 3'h2,
    CL_CORRECT = 3'h4
  } tvd_clamp_t;

endpackage

// ==== sim/tvd_core_bench.sv ====
// Self-checking bench for the converter core with the far side model.
// Assumes tvd_pkg, the core, the FIFO and the partner are compiled.
`timescale 1ns/1ns
`default_nettype none

// ======================================================================
// Bench
// ======================================================================
module tvd_core_bench;
  logic              ref_clk;
  logic              srst;
  logic [8:0]        lv_r, lv_g, lv_b;  // Red, green, blue levels
  logic [1:0]        level_sel_in;
  wire               line_sync_in;
  wire               frame_sync_in;
  wire               stream_ready;
  logic [7:0]        red_code_out;
  logic [7:0]        green_code_out;
  logic [7:0]        blue_code_out;
  logic [23:0]       codes;         // Red, green, blue buses joined
  tvd_pkg::tvd_rgb_t clamp_level_out;
  logic              clamp_integrate_out;
  logic [2:0]        clamp_sink_out;
  logic [2:0]        clamp_source_out;
  logic              buf_in_ready;
  logic              stream_valid;
  tvd_pkg::tvd_rgb_t stream_data;
  int                failures;
  int                tests_run;

  tvd_core i_dut (.ref_clk(ref_clk), .srst(srst),
    .red_level_in(lv_r), .green_level_in(lv_g), .blue_level_in(lv_b),
    .line_sync_in(line_sync_in), .frame_sync_in(frame_sync_in),
    .level_sel_in(level_sel_in), .red_code_out(red_code_out),
    .green_code_out(green_code_out), .blue_code_out(blue_code_out),
    .clamp_level_out(clamp_level_out),
    .clamp_integrate_out(clamp_integrate_out),
    .clamp_sink_out(clamp_sink_out), .clamp_source_out(clamp_source_out),
    .buf_in_ready(buf_in_ready), .stream_valid(stream_valid),
    .stream_ready(stream_ready), .stream_data(stream_data));

  tvd_partner i_far (.ref_clk(ref_clk), .line_sync_in(line_sync_in),
    .frame_sync_in(frame_sync_in), .stream_ready(stream_ready));

  // All three buses as one word, red in the top byte
  assign codes = {red_code_out, green_code_out, blue_code_out};

  // 125 MHz clock
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  // ====================================================================
  // Helpers
  // ====================================================================
  // Ideal code: count thresholds, then take back whole-LSB dither
  function automatic logic [7:0] conv(input logic [8:0] l, input int off);
    int s;
    s = (l + off) / 2;
    if (s > 255) s = 255;
    s = s - off / 2;
    if (s < 0) s = 0;
    return s[7:0];
  endfunction

  function automatic logic [23:0] expv(input int off);
    return {conv(lv_r, off), conv(lv_g, off), conv(lv_b, off)};
  endfunction

  task automatic chk_code(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t code %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t flags %b expected %b", $time, got, exp);
    end
  endtask

  task automatic set_lv(input logic [8:0] r, g, b);
    @(negedge ref_clk);
    lv_r <= r;
    lv_g <= g;
    lv_b <= b;
  endtask

  // ====================================================================
  // Scenarios
  // ====================================================================
  // Clamp idle without line pulses; clamp target table
  task automatic t_clamp_levels();
    logic [23:0] tbl [4];
    tbl = '{24'h101010, 24'h801080, 24'h804080, 24'h101010};
    chk_bit({clamp_integrate_out, 2'h0}, 3'h0);
    chk_bit(clamp_sink_out | clamp_source_out, 3'h0);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge ref_clk) level_sel_in <= 2'(i);
      #1 chk_code(clamp_level_out, tbl[i]);
    end
    $display("clamp levels done");
  endtask

  // New level shows on the third rising edge after its capture
  task automatic t_latency();
    logic [23:0] old;
    set_lv(9'h00a, 9'h12c, 9'h1ff);
    repeat (8) @(negedge ref_clk);
    old = expv(0);
    set_lv(9'h0c9, 9'h1ff, 9'h000);
    @(negedge ref_clk);
    repeat (2) @(posedge ref_clk);
    #1 chk_code(codes, old);
    @(posedge ref_clk);
    #1 chk_code(codes, expv(0));
    $display("latency done");
  endtask

  // Fill the buffer until it refuses, then drain in order
  task automatic t_buffer();
    logic [23:0] a;
    a = expv(0);
    // Let the last word of the old level leave before the stall
    repeat (4) @(negedge ref_clk);
    i_far.set_ready(1'b0);
    repeat (20) @(negedge ref_clk);
    chk_bit({1'b0, stream_valid, buf_in_ready}, 3'h2);
    set_lv(9'h002, 9'h004, 9'h006);
    repeat (10) @(negedge ref_clk);
    i_far.set_ready(1'b1);
    for (int i = 0; i < 12; i++)
    begin
      #1 chk_code(stream_data, (i < 8) ? a : expv(0));
      @(negedge ref_clk);
    end
    $display("buffer done");
  endtask

  // Line steps, frame parity clear, wrap, suppression, clamp sign
  task automatic t_dither();
    set_lv(9'h0c9, 9'h1ff, 9'h000);
    level_sel_in <= 2'h0;
    i_far.set_frame(1'b1);
    chk_code(codes, expv(0));
    // First frame pulse keeps the count, so line steps run 1,2,3,0,1
    for (int i = 1; i < 6; i++)
    begin
      if (i == 3)
      begin
        i_far.set_frame(1'b0);
        chk_code(codes, expv(0));
        i_far.set_frame(1'b1);
        chk_code(codes, expv(2));
      end
      i_far.line_pulse();
      chk_code(codes, expv(i % 4));
    end
    chk_bit(clamp_sink_out, 3'h3);
    chk_bit(clamp_source_out, 3'h4);
    i_far.set_frame(1'b0);
    i_far.set_frame(1'b1);
    chk_code(codes, expv(0));
    $display("dither done");
  endtask

  // Mid-run reset: zero codes, empty buffer, idle clamp, counter cleared
  task automatic t_reset();
    i_far.line_pulse();
    srst <= 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_code(codes, 24'h0);
    chk_bit({stream_valid, buf_in_ready, clamp_integrate_out}, 3'h2);
    srst <= 1'b0;
    repeat (12) @(negedge ref_clk);
    chk_code(codes, expv(0));
    $display("reset done");
  endtask

  // ====================================================================
  // Run control
  // ====================================================================
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // All scenarios take under 1000 cycles; allow a wide margin
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    finish_test();
  end

  initial
  begin
    failures = 0;
    tests_run = 0;
    srst = 1'b1;
    {lv_r, lv_g, lv_b} = 27'h0;
    level_sel_in = 2'h0;
    repeat (20) @(negedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(negedge ref_clk);
    t_clamp_levels();
    t_latency();
    t_buffer();
    t_dither();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire

// ==== sim/tvd_core_properties.sv ====
// Checker for the converter core, bound to its top module.
// Assumes tvd_pkg is compiled first; sees only the core's ports.
`timescale 1ns/1ns
`default_nettype none

// ======================================================================
// Checker
// ======================================================================
module tvd_core_properties #(
  parameter int BUF_DEPTH = tvd_pkg::FIFO_DEPTH
) (
  input wire logic                        ref_clk,
  input wire logic                        srst,
  input wire logic [tvd_pkg::LEVEL_W-1:0] red_level_in,
  input wire logic [tvd_pkg::LEVEL_W-1:0] green_level_in,
  input wire logic [tvd_pkg::LEVEL_W-1:0] blue_level_in,
  input wire logic                        line_sync_in,
  input wire logic                        frame_sync_in,
  input wire logic [1:0]                  level_sel_in,
  input wire logic [tvd_pkg::CODE_W-1:0]  red_code_out,
  input wire logic [tvd_pkg::CODE_W-1:0]  green_code_out,
  input wire logic [tvd_pkg::CODE_W-1:0]  blue_code_out,
  input wire tvd_pkg::tvd_rgb_t           clamp_level_out,
  input wire logic                        clamp_integrate_out,
  input wire logic [tvd_pkg::NUM_CH-1:0]  clamp_sink_out,
  input wire logic [tvd_pkg::NUM_CH-1:0]  clamp_source_out,
  input wire logic                        buf_in_ready,
  input wire logic                        stream_valid,
  input wire logic                        stream_ready,
  input wire tvd_pkg::tvd_rgb_t           stream_data
);
  logic       seen_q;   // Any line pulse since reset
  logic       seen_d;
  logic [3:0] flow_q;   // Consecutive low frame samples, saturating
  logic [3:0] flow_d;

  // Helper state, next values
  always_comb
  begin
    seen_d = seen_q | line_sync_in;
    flow_d = frame_sync_in ? 4'h0
             : ((flow_q == 4'hf) ? flow_q : flow_q + 4'h1);
  end

  // Helper state, registers
  always_ff @(posedge ref_clk)
  begin
    seen_q <= srst ? 1'b0 : seen_d;
    flow_q <= srst ? 4'h0 : flow_d;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // ====================================================================
  // Assertions
  // ====================================================================
  // Long quiet frame means no dither, so the code is the halved level
  a_code_latency: assert property (flow_q == 4'hf |-> ##4
    {red_code_out, green_code_out, blue_code_out} ==
    {$past(red_level_in[8:1], 4), $past(green_level_in[8:1], 4),
     $past(blue_level_in[8:1], 4)})
    else $error("code latency or value wrong");
  a_clamp_low: assert property ((level_sel_in[0] == level_sel_in[1])
    |-> clamp_level_out == 24'h101010) else $error("low clamp level");
  a_clamp_high: assert property ((level_sel_in == 2'h1)
    |-> clamp_level_out == 24'h801080) else $error("high clamp level");
  a_clamp_open: assert property ((level_sel_in == 2'h2)
    |-> clamp_level_out == 24'h804080) else $error("open clamp level");
  a_clamp_needs_line: assert property (!seen_q |->
    !clamp_integrate_out && clamp_sink_out == 3'h0
    && clamp_source_out == 3'h0)
    else $error("clamp active without line pulses");
  a_integrate_starts: assert property ($rose(line_sync_in)
    |-> ##[1:8] clamp_integrate_out) else $error("no integration");
  a_integrate_stops: assert property ($fell(line_sync_in)
    |-> ##[1:8] !clamp_integrate_out) else $error("integration stuck");
  a_sink_source_excl: assert property (
    (clamp_sink_out & clamp_source_out) == 3'h0)
    else $error("sink and source together");
  a_stream_hold: assert property (stream_valid && !stream_ready
    |=> stream_valid && $stable(stream_data)) else $error("word lost");
  a_full_valid: assert property (!buf_in_ready |-> stream_valid)
    else $error("full but not valid");

  c_full: cover property (!buf_in_ready);
  c_correct: cover property ($fell(clamp_integrate_out));
  c_source: cover property (clamp_source_out != 3'h0);
endmodule

bind tvd_core tvd_core_properties #(.BUF_DEPTH(BUF_DEPTH)) i_props (
  .ref_clk(ref_clk), .srst(srst), .red_level_in(red_level_in),
  .green_level_in(green_level_in), .blue_level_in(blue_level_in),
  .line_sync_in(line_sync_in), .frame_sync_in(frame_sync_in),
  .level_sel_in(level_sel_in), .red_code_out(red_code_out),
  .green_code_out(green_code_out), .blue_code_out(blue_code_out),
  .clamp_level_out(clamp_level_out),
  .clamp_integrate_out(clamp_integrate_out),
  .clamp_sink_out(clamp_sink_out), .clamp_source_out(clamp_source_out),
  .buf_in_ready(buf_in_ready), .stream_valid(stream_valid),
  .stream_ready(stream_ready), .stream_data(stream_data));
`default_nettype wire

// ==== sim/tvd_partner.sv ====
// Far side model: sync timing source and downstream consumer.
// Assumes the bench clock; all changes land on falling edges.
`timescale 1ns/1ns
`default_nettype none

// ======================================================================
// Partner
// ======================================================================
module tvd_partner (
  input  wire logic ref_clk,
  output logic      line_sync_in,
  output logic      frame_sync_in,
  output logic      stream_ready
);
  // Idle: no line pulse, frame low (dither off), consumer ready
  initial
  begin
    line_sync_in  = 1'b0;
    frame_sync_in = 1'b0;
    stream_ready  = 1'b1;
  end

  // Line pulse on horizontal sync; long enough for the pin filter
  task automatic line_pulse();
    @(negedge ref_clk) line_sync_in <= 1'b1;
    repeat (8) @(negedge ref_clk);
    line_sync_in <= 1'b0;
    repeat (12) @(negedge ref_clk);
  endtask

  // Frame level; a low-going level is one frame pulse
  task automatic set_frame(input logic v);
    @(negedge ref_clk) frame_sync_in <= v;
    repeat (12) @(negedge ref_clk);
  endtask

  // Consumer stall control
  task automatic set_ready(input logic v);
    @(negedge ref_clk) stream_ready <= v;
  endtask
endmodule
`default_nettype wire
